// ==== hdl/bcps_defines.vh ====
// Purpose: constants for the port E bus control pin select block
// Assumes: 32-bit APB data, one word per register
// Notes:   field positions are bit numbers inside each register
`ifndef BCPS_DEFINES_VH
`define BCPS_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BCPS_OFS_ASSIGN    12'h000
`define BCPS_OFS_MODE      12'h004
`define BCPS_OFS_SLOWDIV   12'h008
`define BCPS_OFS_STRETCH   12'h00c
`define BCPS_OFS_PDATA     12'h010
`define BCPS_OFS_PDIR      12'h014
`define BCPS_OFS_PPINS     12'h018

// ---------------------------------------------------------------
// assignment register fields
// ---------------------------------------------------------------
`define BCPS_BIT_STRB_DIS   7
`define BCPS_BIT_CTEST_EN   6
`define BCPS_BIT_QUEUE_OE   5
`define BCPS_BIT_INVCLK_SEL 4
`define BCPS_BIT_LBS_EN     3
`define BCPS_BIT_DIR_EN     2
`define BCPS_BIT_REF_EN     0
`define BCPS_ASSIGN_MASK   8'hfd
`define BCPS_ASSIGN_RST    8'h80

// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define BCPS_BIT_MODE_A    0
`define BCPS_BIT_MODE_B    1
`define BCPS_BIT_SPECIAL   2
`define BCPS_BIT_EXPANDED  3

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define BCPS_SLOWDIV_RST   8'h00
`define BCPS_STRETCH_RST   2'h0
`define BCPS_PORT_RST      6'h00
`define BCPS_CAPTURE_WAIT  2'h2
`define BCPS_PH_HIGH_LAST  2'h3

`endif

// ==== hdl/bcps_pin_select.v ====
// Purpose: port E bus control pin select with APB register slave
// Assumes: pclk is twice the crystal rate; bus clock is pclk/4
// Notes:   all pin outputs are registered, one pclk behind phase
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bcps_defines.vh"

module bcps_pin_select (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire        bus_access,
   input  wire        bus_read,
   input  wire        bus_addr0,
   input  wire        access_size_flag,
   input  wire [1:0]  queue_state,
   input  wire        clock_test_src,
   input  wire        special_mode_pin_n,
   input  wire [7:2]  porte_in,
   output reg  [7:2]  porte_out,
   output reg  [7:2]  porte_oe,
   output reg         bus_clock_out,
   output reg         ext_read_drive_en,
   output reg         ad_bus_select
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   reg  [7:0]  sync1_r;
   reg  [7:0]  sync2_r;
   wire [7:0]  raw_in;

   assign raw_in = {clock_test_src, special_mode_pin_n, porte_in};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   wire [7:2]  pins_s;
   wire        spec_pin_n_s;
   wire        ctest_s;

   assign pins_s  = sync2_r[5:0];
   assign spec_pin_n_s = sync2_r[6];
   assign ctest_s = sync2_r[7];

   // ---------------------------------------------------------------
   // mode capture at reset release
   // ---------------------------------------------------------------
   function is_expanded;
      input [2:0] m;
      begin
         is_expanded = m[`BCPS_BIT_MODE_A];
      end
   endfunction

   reg  [1:0]  cap_cnt_r;
   reg         captured_r;
   reg  [2:0]  mode_r;
   wire        expanded;
   wire [2:0]  mode_pins;

   // porte bit5 is mode_pin_b, bit4 is mode_pin_a
   assign mode_pins = {~spec_pin_n_s, pins_s[5], pins_s[4]};
   assign expanded  = is_expanded(mode_r);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_cnt_r  <= 2'h0;
         captured_r <= 1'b0;
         mode_r     <= 3'h0;
      end else if (!captured_r) begin
         if (cap_cnt_r == `BCPS_CAPTURE_WAIT) begin
            captured_r <= 1'b1;
            mode_r     <= mode_pins;
         end else begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   reg  [7:0]  assign_r;
   reg  [7:0]  slowdiv_r;
   reg  [1:0]  stretch_r;
   reg  [7:2]  pdata_r;
   reg  [7:2]  pdir_r;
   wire        wr_en;
   wire        setup;

   assign pready = captured_r;
   assign setup  = psel & ~penable;
   assign wr_en  = psel & penable & pready & pwrite;

   wire strobe_disable_bit      = assign_r[`BCPS_BIT_STRB_DIS];
   wire clock_test_enable       = assign_r[`BCPS_BIT_CTEST_EN];
   wire queue_pin_output_enable = assign_r[`BCPS_BIT_QUEUE_OE];
   wire inverted_clock_select   = assign_r[`BCPS_BIT_INVCLK_SEL];
   wire strobe_pin_enable       = assign_r[`BCPS_BIT_LBS_EN];
   wire direction_pin_enable    = assign_r[`BCPS_BIT_DIR_EN];
   wire reference_output_enable = assign_r[`BCPS_BIT_REF_EN];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         assign_r  <= `BCPS_ASSIGN_RST;
         slowdiv_r <= `BCPS_SLOWDIV_RST;
         stretch_r <= `BCPS_STRETCH_RST;
         pdata_r   <= `BCPS_PORT_RST;
         pdir_r    <= `BCPS_PORT_RST;
      end else if (!captured_r) begin
         if (cap_cnt_r == `BCPS_CAPTURE_WAIT)
            assign_r[`BCPS_BIT_STRB_DIS] <= ~is_expanded(mode_pins);
      end else if (wr_en) begin
         case (paddr)
            `BCPS_OFS_ASSIGN:  assign_r  <= pwdata[7:0] & `BCPS_ASSIGN_MASK;
            `BCPS_OFS_SLOWDIV: slowdiv_r <= pwdata[7:0];
            `BCPS_OFS_STRETCH: stretch_r <= pwdata[1:0];
            `BCPS_OFS_PDATA:   pdata_r   <= pwdata[7:2];
            `BCPS_OFS_PDIR:    pdir_r    <= pwdata[7:2];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // apb read data, captured in the setup cycle
   // ---------------------------------------------------------------
   reg  [31:0] rd_nxt;
   reg         err_nxt;

   always @* begin
      rd_nxt  = 32'h00000000;
      err_nxt = 1'b0;
      case (paddr)
         `BCPS_OFS_ASSIGN:  rd_nxt[7:0] = assign_r;
         `BCPS_OFS_MODE:    rd_nxt[3:0] = {expanded, mode_r};
         `BCPS_OFS_SLOWDIV: rd_nxt[7:0] = slowdiv_r;
         `BCPS_OFS_STRETCH: rd_nxt[1:0] = stretch_r;
         `BCPS_OFS_PDATA:   rd_nxt[7:2] = pdata_r;
         `BCPS_OFS_PDIR:    rd_nxt[7:2] = pdir_r;
         `BCPS_OFS_PPINS:   rd_nxt[7:2] = pins_s;
         default:           err_nxt     = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_nxt;
         pslverr <= err_nxt;
      end
   end

   // ---------------------------------------------------------------
   // bus clock phase and stretch
   // ---------------------------------------------------------------
   // ph[0] is the crystal, ph[1] the bus clock; one pclk is a quarter
   reg  [1:0]  ph_r;
   reg  [1:0]  stretch_cnt_r;
   reg         stretched_r;
   reg         access_r;
   reg         read_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r          <= 2'h0;
         stretch_cnt_r <= 2'h0;
         stretched_r   <= 1'b0;
         access_r      <= 1'b0;
         read_r        <= 1'b0;
      end else begin
         ph_r <= ph_r + 2'h1;
         if (ph_r == `BCPS_PH_HIGH_LAST) begin
            if (stretch_cnt_r != 2'h0) begin
               stretch_cnt_r <= stretch_cnt_r - 2'h1;
            end else begin
               access_r      <= bus_access & expanded;
               read_r        <= bus_read;
               stretch_cnt_r <= bus_access ? stretch_r : 2'h0;
               stretched_r   <= bus_access & (stretch_r != 2'h0);
            end
         end
      end
   end

   wire last_cycle = (stretch_cnt_r == 2'h0);
   wire bus_clk_int = ph_r[1] & last_cycle;
   wire strobe_win  = stretched_r ? (last_cycle &
                     (ph_r == `BCPS_PH_HIGH_LAST))
                     : bus_clk_int;

   // ---------------------------------------------------------------
   // slow divider clock, toggles every slowdiv+1 pclk
   // ---------------------------------------------------------------
   reg  [7:0]  slow_cnt_r;
   reg         slow_clk_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_cnt_r <= 8'h00;
         slow_clk_r <= 1'b0;
      end else if (slow_cnt_r >= slowdiv_r) begin
         slow_cnt_r <= 8'h00;
         slow_clk_r <= ~slow_clk_r;
      end else begin
         slow_cnt_r <= slow_cnt_r + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // pin multiplexing
   // ---------------------------------------------------------------
   reg  [7:2]  out_nxt;
   reg  [7:2]  oe_nxt;

   always @* begin
      out_nxt = pdata_r;
      oe_nxt  = pdir_r;
      if (!strobe_disable_bit) begin
         oe_nxt[7] = 1'b1;
         if (inverted_clock_select)
            out_nxt[7] = ~bus_clk_int;
         else
            out_nxt[7] = ~(strobe_win & access_r);
      end else if (reference_output_enable) begin
         oe_nxt[7]  = 1'b1;
         out_nxt[7] = slow_clk_r;
      end
      if (clock_test_enable && !queue_pin_output_enable) begin
         oe_nxt[6]  = 1'b1;
         out_nxt[6] = ctest_s;
      end
      if (queue_pin_output_enable) begin
         oe_nxt[5:4]  = 2'b11;
         out_nxt[5:4] = queue_state;
      end
      if (strobe_pin_enable && expanded) begin
         oe_nxt[3]  = 1'b1;
         out_nxt[3] = ~(bus_addr0 ^ access_size_flag);
      end
      if (direction_pin_enable && expanded) begin
         oe_nxt[2]  = 1'b1;
         out_nxt[2] = bus_read;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         porte_out         <= 6'h00;
         porte_oe          <= 6'h00;
         bus_clock_out     <= 1'b0;
         ext_read_drive_en <= 1'b0;
         ad_bus_select     <= 1'b0;
      end else begin
         porte_out     <= out_nxt;
         porte_oe      <= oe_nxt;
         bus_clock_out <= bus_clk_int;
         ext_read_drive_en <= expanded & access_r & read_r
                              & strobe_win & ~strobe_disable_bit;
         ad_bus_select <= expanded;
      end
   end

endmodule // bcps_pin_select
`default_nettype wire

// ==== verif/bcps_ext_bus_model.sv ====
// Purpose: port e wiring as seen by external bus parts
// Assumes: released pins pulled up, mode pins strapped by bench
// Notes:   strap stays up past the mode capture after reset
`timescale 1ns/1ps
`default_nettype none
module bcps_ext_bus_model (
   input  wire logic       strap,
   input  wire logic       mode_a,
   input  wire logic       mode_b,
   input  wire logic [7:2] porte_out,
   input  wire logic [7:2] porte_oe,
   output logic      [7:2] porte_in
);
   always_comb begin
      porte_in = (porte_out & porte_oe) | ~porte_oe;
      if (strap)
         porte_in[5:4] = {mode_b, mode_a};
   end
endmodule // bcps_ext_bus_model
`default_nettype wire

// ==== verif/bcps_pin_select_assertions.sv ====
// Purpose: port checks for the bus control pin select
// Assumes: assign and stretch registers shadowed from apb writes
// Notes:   pin outputs and bus clock carry the same one pclk lag
`timescale 1ns/1ps
`default_nettype none
`include "bcps_defines.vh"
module bcps_pin_select_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        bus_read,
   input wire logic        bus_addr0,
   input wire logic        access_size_flag,
   input wire logic [7:2]  porte_out,
   input wire logic [7:2]  porte_oe,
   input wire logic        bus_clock_out,
   input wire logic        ext_read_drive_en,
   input wire logic        ad_bus_select
);
   logic [7:0] asg_r;
   logic [1:0] str_r;
   logic [3:0] hold_r;
   logic       seen_r;
   wire        wr = psel && penable && pready && pwrite;
   // config settled: no recent write to assign or stretch
   wire        ok = seen_r && hold_r == 4'h0;
   wire        dbe_on = ok && !asg_r[7] && !asg_r[4];
   wire        inv_on = ok && !asg_r[7] && asg_r[4];
   wire        ls_on = ok && ad_bus_select && asg_r[3];
   wire        rw_on = ok && ad_bus_select && asg_r[2];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asg_r <= 8'h00;
         str_r <= 2'h0;
         hold_r <= 4'hf;
         seen_r <= 1'b0;
      end else begin
         hold_r <= (hold_r != 4'h0) ? hold_r - 4'h1 : 4'h0;
         if (wr && paddr == `BCPS_OFS_ASSIGN) begin
            asg_r <= pwdata[7:0];
            seen_r <= 1'b1;
            hold_r <= 4'hf;
         end
         if (wr && paddr == `BCPS_OFS_STRETCH) begin
            str_r <= pwdata[1:0];
            hold_r <= 4'hf;
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_capture_a: assert property ($rose(presetn) |->
      !pready ##1 !pready ##1 !pready ##1 pready) else $error("pready late");
   strobe_in_high_a: assert property (dbe_on && !porte_out[7]
      |-> bus_clock_out) else $error("strobe outside bus clock high");
   strobe_last_qtr_a: assert property (dbe_on && str_r != 2'h0
      && $fell(porte_out[7]) |=> porte_out[7]) else $error("long strobe");
   inv_clock_a: assert property (inv_on |-> porte_oe[7]
      && porte_out[7] != bus_clock_out) else $error("not inverted clock");
   bus_clk_period_a: assert property (ok && str_r == 2'h0
      && $rose(bus_clock_out) |=> bus_clock_out ##1 !bus_clock_out[*2]
      ##1 bus_clock_out) else $error("bus clock period wrong");
   low_strobe_xnor_a: assert property (ls_on |-> porte_out[3] ==
      !($past(bus_addr0) ^ $past(access_size_flag))) else $error("low byte");
   rw_direction_a: assert property (rw_on |-> porte_oe[2]
      && porte_out[2] == $past(bus_read)) else $error("read/write pin");
   read_drive_a: assert property (ext_read_drive_en
      |-> ad_bus_select) else $error("read drive outside expanded");
   mode_fixed_a: assert property (pready && $past(pready, 2)
      |-> $stable(ad_bus_select)) else $error("mode changed");
   cover property (dbe_on && !porte_out[7]);
   cover property (dbe_on && str_r != 2'h0 && $fell(porte_out[7]));
   cover property (inv_on && $rose(bus_clock_out));
endmodule // bcps_pin_select_assertions
bind bcps_pin_select bcps_pin_select_assertions chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .bus_read, .bus_addr0,
   .access_size_flag, .porte_out, .porte_oe, .bus_clock_out,
   .ext_read_drive_en, .ad_bus_select);
`default_nettype wire

// ==== verif/test_bus_control_pin_select.sv ====
// Purpose: self-checking bench for the bus control pin select
// Assumes: seeded random bus traffic, apb register access
// Notes:   ends through test_done only
`timescale 1ns/1ps
`default_nettype none
`include "bcps_defines.vh"
module test_bus_control_pin_select;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        bus_access, bus_read, bus_addr0, access_size_flag;
   logic        clock_test_src, special_mode_pin_n, strap, mode_a, mode_b;
   logic        bus_clock_out, ext_read_drive_en, ad_bus_select;
   logic [1:0]  queue_state;
   logic [7:2]  porte_in, porte_out, porte_oe;
   int          mismatches = 0, comparisons = 0;
   bcps_pin_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bus_access, .bus_read,
      .bus_addr0, .access_size_flag, .queue_state, .clock_test_src,
      .special_mode_pin_n, .porte_in, .porte_out, .porte_oe,
      .bus_clock_out, .ext_read_drive_en, .ad_bus_select);
   bcps_ext_bus_model ext (.strap, .mode_a, .mode_b, .porte_out, .porte_oe,
      .porte_in);
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic test_done;
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic lstr(input logic a, input logic s);
      return ~(a ^ s);
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic boot(input logic a);
      presetn <= 1'b0;
      strap <= 1'b1;
      mode_a <= a;
      mode_b <= $urandom;
      special_mode_pin_n <= $urandom;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      strap <= 1'b0;
      apb(0, `BCPS_OFS_MODE, 0);
      chk(rd, {a, ~special_mode_pin_n, mode_b, a});
      chk(ad_bus_select, a);
      apb(0, `BCPS_OFS_ASSIGN, 0);
      chk(rd, {~a, 7'h00});
      chk(porte_oe[3:2], 2'h0);
   endtask
   task automatic traffic(input int k);
      repeat (k) begin
         bus_access <= $urandom;
         bus_read <= $urandom;
         bus_addr0 <= $urandom;
         access_size_flag <= $urandom;
         @(posedge pclk);
      end
   endtask
   task automatic count7(input int exp);
      logic [31:0] h = 0;
      repeat (16) begin
         @(posedge pclk);
         h += porte_out[7];
      end
      chk(h, exp);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, bus_access, bus_read} <= '0;
      {bus_addr0, access_size_flag, queue_state, clock_test_src} <= '0;
      void'($urandom(84871));
      boot(1'b1);
      apb(0, `BCPS_OFS_SLOWDIV, 0);
      chk(rd, 0);
      apb(1, `BCPS_OFS_ASSIGN, 32'h81);
      count7(8);
      apb(0, 12'h01c, 0);
      chk(pslverr, 1);
      chk(rd, 0);
      apb(1, `BCPS_OFS_ASSIGN, 32'h0d);
      traffic(200);
      repeat (16) begin
         bus_addr0 <= $urandom;
         access_size_flag <= $urandom;
         bus_read <= $urandom;
         repeat (2) @(posedge pclk);
         chk(porte_out[3], lstr(bus_addr0, access_size_flag));
         chk(porte_out[2], bus_read);
      end
      apb(1, `BCPS_OFS_STRETCH, 2);
      traffic(200);
      apb(1, `BCPS_OFS_STRETCH, 0);
      apb(1, `BCPS_OFS_ASSIGN, 32'h10);
      traffic(40);
      chk(porte_out[7], !bus_clock_out);
      apb(1, `BCPS_OFS_SLOWDIV, 1);
      apb(1, `BCPS_OFS_ASSIGN, 32'h81);
      count7(8);
      apb(1, `BCPS_OFS_PDIR, 32'h80);
      apb(1, `BCPS_OFS_ASSIGN, 32'h80);
      count7(0);
      apb(1, `BCPS_OFS_ASSIGN, 32'hc0);
      for (int v = 1; v >= 0; v--) begin
         clock_test_src <= v[0];
         repeat (5) @(posedge pclk);
         chk({porte_oe[6], porte_out[6]}, {1'b1, v[0]});
      end
      apb(1, `BCPS_OFS_ASSIGN, 32'he0);
      queue_state <= 2'h2;
      repeat (3) @(posedge pclk);
      chk(porte_out[5:4], 2'h2);
      chk(porte_oe[6], 0);
      boot(1'b0);
      apb(1, `BCPS_OFS_ASSIGN, 32'h0c);
      traffic(20);
      chk(porte_oe[3:2], 2'h0);
      test_done;
   end
   initial begin
      #40000;
      mismatches++;
      test_done;
   end
endmodule // test_bus_control_pin_select
`default_nettype wire
